// ### core/dtc_debug_trigger_control.sv
`timescale 1ns/10ps
module dtc_debug_trigger_control
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Chip security
  input  wire logic        chipSecure,
  // Bus watch inputs from comparators and opcode tracker
  input  wire logic        busValid,
  input  wire logic        busRead,
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] cmpAValue,
  input  wire logic [15:0] cmpBValue,
  input  wire logic        dataBMatch,
  input  wire logic        opExecA,
  input  wire logic        opExecB,
  // Trace FIFO side
  input  wire logic        fifoFull,
  output logic             fifoStore,
  output logic             fifoCircular,
  output logic             eventOnly,
  output logic             runStart,
  // CPU break side
  output logic             breakReq,
  output logic             breakTag
);

  // ==========================================================
  // Helpers
  function automatic logic dir_ok(input logic qual, input logic want, input logic rd);
    dir_ok = !qual || (want == rd);
  endfunction

  function automatic logic is_event_only(input logic [3:0] m);
    is_event_only = (m == DTC_EV_B) || (m == DTC_A_EV_B);
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] control_q, control_d;
  logic [7:0] trigger_q, trigger_d;
  logic       runFlag_q, runFlag_d;
  logic       ackQ_q,    ackQ_d;
  logic [31:0] rdata_q,  rdata_d;
  dtc_state_e state_q,   state_d;
  logic       brk_q,     brk_d;
  logic       start_q,   start_d;
  logic       begun_q,   begun_d;
  logic       secureS1_q, secureS2_q;

  logic       wbReq, wrCtl, wrTrg, mapped;
  logic       enable, armed, beginTrace;
  logic       rawA, rawB, matchA, matchB, hitA, hitB, inRange;
  logic       trigger, complete;
  logic [3:0] mode;

  assign wbReq  = wb_cyc_i && wb_stb_i && !ackQ_q;
  assign mapped = (wb_adr_i == OFS_CONTROL) || (wb_adr_i == OFS_TRIGGER)
               || (wb_adr_i == OFS_STATUS);
  assign wrCtl  = wbReq && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_CONTROL);
  assign wrTrg  = wbReq && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_TRIGGER);
  assign enable = control_q[BIT_ENABLE];
  assign armed  = control_q[BIT_ARM] && enable;
  assign mode   = trigger_q[3:0];

  // ==========================================================
  // Comparator qualification
  always_comb begin
    rawA    = busValid && (busAddr == cmpAValue);
    rawB    = busValid && (busAddr == cmpBValue);
    matchA  = rawA && dir_ok(control_q[BIT_CMP_A_DIRECTION_QUALIFY], control_q[BIT_RWA], busRead);
    matchB  = rawB && dir_ok(control_q[BIT_CMP_B_DIRECTION_QUALIFY], control_q[BIT_RWB], busRead);
    // Opcode qualify select lets only executed opcodes through
    hitA    = trigger_q[BIT_TRIGGER_QUALIFY_SELECT] ? (matchA && opExecA) : matchA;
    hitB    = trigger_q[BIT_TRIGGER_QUALIFY_SELECT] ? (matchB && opExecB) : matchB;
    inRange = busValid && (busAddr >= cmpAValue) && (busAddr <= cmpBValue);
    beginTrace = trigger_q[BIT_BEGIN] || is_event_only(mode);
  end

  // ==========================================================
  // Trigger detection and run sequencing
  always_comb begin
    state_d = state_q;
    trigger = 1'b0;
    start_d = 1'b0;
    case (mode)
      DTC_A_ONLY:   trigger = hitA;
      DTC_A_OR_B:   trigger = hitA || hitB;
      DTC_A_THEN_B: trigger = (state_q == DTC_RUN) && hitB;
      DTC_EV_B:     trigger = hitB;
      DTC_A_EV_B:   trigger = (state_q == DTC_RUN) && hitB;
      DTC_A_AND_B:  trigger = hitA && dataBMatch;
      DTC_A_NAND_B: trigger = hitA && !dataBMatch;
      DTC_INSIDE:   trigger = inRange;
      DTC_OUTSIDE:  trigger = busValid && ((busAddr < cmpAValue) || (busAddr > cmpBValue));
      default:      trigger = 1'b0;
    endcase
    case (state_q)
      DTC_IDLE: begin
        if (armed) begin
          state_d = DTC_WAITA;
          start_d = 1'b1;
        end
      end
      DTC_WAITA: begin
        if (!armed) begin
          state_d = DTC_IDLE;
        end else if (hitA) begin
          state_d = DTC_RUN;
        end
      end
      DTC_RUN: begin
        if (!armed) begin
          state_d = DTC_IDLE;
        end
      end
      default: state_d = DTC_IDLE;
    endcase
    // Begin trace ends on full, end trace ends on trigger
    complete = armed && (beginTrace ? fifoFull : trigger);
    // Same timing whether qualify select is access or opcode
    brk_d    = complete && control_q[BIT_BREAK_REQUEST_ENABLE];
    // Begin trace stores only once its trigger has been seen
    begun_d  = armed && (begun_q || (beginTrace && trigger));
  end

  // ==========================================================
  // Register file
  always_comb begin
    control_d = control_q;
    trigger_d = trigger_q;
    runFlag_d = runFlag_q;
    if (complete) begin
      control_d[BIT_ARM] = 1'b0;
      runFlag_d          = 1'b0;
    end
    if (wrCtl) begin
      control_d = wb_dat_i[7:0];
      control_d[BIT_ENABLE] = wb_dat_i[BIT_ENABLE] && !secureS2_q;
      runFlag_d = wb_dat_i[BIT_ARM] && control_d[BIT_ENABLE];
      if (!wb_dat_i[BIT_ARM] || !wb_dat_i[BIT_ENABLE]) begin
        control_d[BIT_ARM] = 1'b0;
        runFlag_d          = 1'b0;
      end
    end
    if (wrTrg && !control_q[BIT_ARM]) begin
      trigger_d = wb_dat_i[7:0] & TRIG_WMASK;
    end
    ackQ_d  = wb_cyc_i && wb_stb_i && !ackQ_q;
    rdata_d = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CONTROL: rdata_d = {24'h00_0000, control_q};
      OFS_TRIGGER: rdata_d = {24'h00_0000, trigger_q & TRIG_WMASK};
      OFS_STATUS:  rdata_d = {30'h0000_0000, state_q != DTC_IDLE, runFlag_q && enable};
      default:     rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      control_q  <= CONTROL_RST;
      trigger_q  <= TRIGGER_RST;
      runFlag_q  <= 1'b0;
      ackQ_q     <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      state_q    <= DTC_IDLE;
      brk_q      <= 1'b0;
      start_q    <= 1'b0;
      begun_q    <= 1'b0;
      secureS1_q <= 1'b1;
      secureS2_q <= 1'b1;
    end else begin
      control_q  <= control_d;
      trigger_q  <= trigger_d;
      runFlag_q  <= runFlag_d;
      ackQ_q     <= ackQ_d;
      rdata_q    <= rdata_d;
      state_q    <= state_d;
      brk_q      <= brk_d;
      start_q    <= start_d;
      begun_q    <= begun_d;
      secureS1_q <= chipSecure;
      secureS2_q <= secureS1_q;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o     = ackQ_q && mapped;
  assign wb_err_o     = ackQ_q && !mapped;
  assign wb_dat_o     = rdata_q;
  assign breakReq     = brk_q;
  assign breakTag     = brk_q && control_q[BIT_TAG];
  assign fifoStore    = armed && (!beginTrace || begun_q || trigger);
  assign fifoCircular = !beginTrace;
  assign eventOnly    = is_event_only(mode);
  assign runStart     = start_q;

  // ==========================================================
  // Checks
  a_secure_enable: assert property (@(posedge core_clk) disable iff (!rstn)
    secureS2_q && !control_q[BIT_ENABLE] |=> !control_q[BIT_ENABLE])
    else $error("enable set while secure");
  a_arm_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wrCtl && wb_dat_i[BIT_ARM] && wb_dat_i[BIT_ENABLE] && !secureS2_q
    |=> control_q[BIT_ARM] && runFlag_q)
    else $error("arm write not taken");
  a_manual_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    wrCtl && !wb_dat_i[BIT_ARM] |=> !control_q[BIT_ARM] && !runFlag_q)
    else $error("run not stopped");
  a_break_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    breakReq |-> $past(control_q[BIT_BREAK_REQUEST_ENABLE]) && $past(armed))
    else $error("break without enable");
  a_tag_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    breakTag |-> breakReq)
    else $error("tag without break");
  a_begin_full: assert property (@(posedge core_clk) disable iff (!rstn)
    armed && beginTrace && fifoFull && !wrCtl |=> !control_q[BIT_ARM])
    else $error("begin run not completed");
  a_trg_locked: assert property (@(posedge core_clk) disable iff (!rstn)
    control_q[BIT_ARM] |=> $stable(trigger_q))
    else $error("trigger written while armed");
  a_trg_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    trigger_q[5:4] == 2'b00)
    else $error("reserved trigger bits set");
  a_no_trigger: assert property (@(posedge core_clk) disable iff (!rstn)
    mode > 4'h8 |-> !trigger)
    else $error("reserved mode triggered");
  a_event_begin: assert property (@(posedge core_clk) disable iff (!rstn)
    is_event_only(mode) |-> !fifoCircular)
    else $error("event mode not begin trace");
  a_event_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    eventOnly |-> beginTrace)
    else $error("event flag without begin trace");

  // ==========================================================
  // Bus checks
  a_ack_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_only: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_err_o |-> !wb_ack_o)
    else $error("ack and error together");
  a_ctl_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wrCtl |=> control_q[5:0] == $past(wb_dat_i[5:0]))
    else $error("control write lost");
  a_trg_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wrTrg && !control_q[BIT_ARM] |=> trigger_q == ($past(wb_dat_i[7:0]) & TRIG_WMASK))
    else $error("trigger write lost");
  a_enable_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    wrCtl && !wb_dat_i[BIT_ENABLE] |=> !armed)
    else $error("run not stopped by enable");

  // ==========================================================
  // Break and run checks
  a_break_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    breakReq && !$past(wrCtl) |-> !control_q[BIT_ARM])
    else $error("arm kept after break");
  a_tag_force: assert property (@(posedge core_clk) disable iff (!rstn)
    breakReq && !control_q[BIT_TAG] |-> !breakTag)
    else $error("tag break in force mode");
  a_tag_follow: assert property (@(posedge core_clk) disable iff (!rstn)
    breakReq && control_q[BIT_TAG] |-> breakTag)
    else $error("force break in tag mode");
  a_brk_off: assert property (@(posedge core_clk) disable iff (!rstn)
    !control_q[BIT_BREAK_REQUEST_ENABLE] && !$past(control_q[BIT_BREAK_REQUEST_ENABLE]) |-> !breakReq)
    else $error("break while disabled");
  a_end_break: assert property (@(posedge core_clk) disable iff (!rstn)
    armed && !beginTrace && trigger && control_q[BIT_BREAK_REQUEST_ENABLE] |=> breakReq)
    else $error("end trace break missing");
  a_full_break: assert property (@(posedge core_clk) disable iff (!rstn)
    armed && beginTrace && fifoFull && control_q[BIT_BREAK_REQUEST_ENABLE] |=> breakReq)
    else $error("begin trace break missing");
  a_run_start: assert property (@(posedge core_clk) disable iff (!rstn)
    runStart |-> $past(armed))
    else $error("run start while not armed");
  a_store_off: assert property (@(posedge core_clk) disable iff (!rstn)
    !armed |-> !fifoStore)
    else $error("store while not armed");
  a_begin_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    armed && beginTrace && !begun_q && !trigger |-> !fifoStore)
    else $error("begin trace stored early");
  a_circ_end: assert property (@(posedge core_clk) disable iff (!rstn)
    !trigger_q[BIT_BEGIN] && !is_event_only(mode) |-> fifoCircular)
    else $error("end trace not circular");
  a_circ_begin: assert property (@(posedge core_clk) disable iff (!rstn)
    trigger_q[BIT_BEGIN] |-> !fifoCircular)
    else $error("begin trace circular");

  // ==========================================================
  // Match checks
  a_opcode_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    trigger_q[BIT_TRIGGER_QUALIFY_SELECT] && !opExecA |-> !hitA)
    else $error("unexecuted opcode hit");
  a_dir_a: assert property (@(posedge core_clk) disable iff (!rstn)
    control_q[BIT_CMP_A_DIRECTION_QUALIFY] && (busRead != control_q[BIT_RWA]) |-> !matchA)
    else $error("comparator A wrong direction");
  a_free_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !control_q[BIT_CMP_A_DIRECTION_QUALIFY] && rawA |-> matchA)
    else $error("comparator A direction used");
  a_dir_b: assert property (@(posedge core_clk) disable iff (!rstn)
    control_q[BIT_CMP_B_DIRECTION_QUALIFY] && (busRead != control_q[BIT_RWB]) |-> !matchB)
    else $error("comparator B wrong direction");
  a_free_b: assert property (@(posedge core_clk) disable iff (!rstn)
    !control_q[BIT_CMP_B_DIRECTION_QUALIFY] && rawB |-> matchB)
    else $error("comparator B direction used");
  a_then_b: assert property (@(posedge core_clk) disable iff (!rstn)
    mode == DTC_A_THEN_B && state_q != DTC_RUN |-> !trigger)
    else $error("B before A");
  a_nand_b: assert property (@(posedge core_clk) disable iff (!rstn)
    mode == DTC_A_NAND_B && dataBMatch |-> !trigger)
    else $error("nand mode fired on data match");
  a_range_in: assert property (@(posedge core_clk) disable iff (!rstn)
    mode == DTC_INSIDE && busValid && busAddr >= cmpAValue && busAddr <= cmpBValue
    |-> trigger)
    else $error("inside range missed");

endmodule

// ### core/dtc_pkg.sv
package dtc_pkg;
  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TRIGGER = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  // ==========================================================
  // Control register fields
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_ARM      = 6;
  localparam int BIT_TAG      = 5;
  localparam int BIT_BREAK_REQUEST_ENABLE    = 4;
  localparam int BIT_RWA      = 3;
  localparam int BIT_CMP_A_DIRECTION_QUALIFY    = 2;
  localparam int BIT_RWB      = 1;
  localparam int BIT_CMP_B_DIRECTION_QUALIFY    = 0;
  // ==========================================================
  // Trigger register fields
  localparam int BIT_TRIGGER_QUALIFY_SELECT   = 7;
  localparam int BIT_BEGIN    = 6;
  localparam logic [7:0] TRIG_WMASK = 8'hCF;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] TRIGGER_RST = 8'h00;
  // ==========================================================
  // Trigger modes
  typedef enum logic [3:0] {
    DTC_A_ONLY   = 4'h0,
    DTC_A_OR_B   = 4'h1,
    DTC_A_THEN_B = 4'h2,
    DTC_EV_B     = 4'h3,
    DTC_A_EV_B   = 4'h4,
    DTC_A_AND_B  = 4'h5,
    DTC_A_NAND_B = 4'h6,
    DTC_INSIDE   = 4'h7,
    DTC_OUTSIDE  = 4'h8
  } dtc_mode_e;
  // Run sequencer states, Gray along idle-wait-run
  typedef enum logic [1:0] {
    DTC_IDLE  = 2'b00,
    DTC_WAITA = 2'b01,
    DTC_RUN   = 2'b11
  } dtc_state_e;
endpackage

// ### sim/dtc_far_model.sv
`timescale 1ns/10ps
module dtc_far_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Trace side
  input  wire logic busValid,
  input  wire logic fifoStore,
  output logic      fifoFull
);
  // ==========================================
  // Eight-word trace FIFO fill level
  logic [3:0] cntQ;
  logic [3:0] cntD;
  always_comb begin
    cntD = cntQ;
    if (!fifoStore) begin
      cntD = 4'h0;
    end else if (busValid && cntQ != 4'h8) begin
      cntD = cntQ + 4'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cntQ <= 4'h0;
    end else begin
      cntQ <= cntD;
    end
  end
  assign fifoFull = (cntQ == 4'h8);
endmodule

// ### sim/dtc_debug_trigger_control_tb_top.sv
`timescale 1ns/10ps
module dtc_debug_trigger_control_tb_top;
  import dtc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, wbErr;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0, wbDatO, r;
  logic        chipSecure = 1'b0, busValid = 1'b0, busRead = 1'b0;
  logic        dataBMatch = 1'b0, opExecA = 1'b0, opExecB = 1'b0;
  logic [15:0] busAddr = 16'h0, cmpA = 16'h0, cmpB = 16'h0;
  logic        fifoFull, fifoStore, breakReq, breakTag;
  logic [33:0] e;
  logic [33:0] notes[$];
  int          num_errors = 0;
  int          checked = 0;
  always #2 core_clk = ~core_clk;
  dtc_debug_trigger_control uut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr), .chipSecure(chipSecure),
    .busValid(busValid), .busRead(busRead), .busAddr(busAddr), .cmpAValue(cmpA),
    .cmpBValue(cmpB), .dataBMatch(dataBMatch), .opExecA(opExecA), .opExecB(opExecB),
    .fifoFull(fifoFull),
    .fifoStore(fifoStore), .fifoCircular(), .eventOnly(), .runStart(), .breakReq(breakReq),
    .breakTag(breakTag));
  dtc_far_model far (.core_clk(core_clk), .rstn(rstn), .busValid(busValid),
    .fifoStore(fifoStore), .fifoFull(fifoFull));
  // ==========================================
  // Compare and report
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Result watcher: 0 read data, 1 bus error, 2 break
  always @(negedge core_clk) begin
    if (rstn && ((wbAck && !wbWe) || wbErr || breakReq)) begin
      e = (notes.size() != 0) ? notes.pop_front() : {2'd3, 32'h0};
      cmp_word("kind", {30'h0, e[33:32]}, breakReq ? 32'd2 : (wbErr ? 32'd1 : 32'd0));
      if (e[33:32] == 2'd0) cmp_word("rdata", e[31:0], wbDatO);
      if (e[33:32] == 2'd2) cmp_bit("breakTag", e[0], breakTag);
    end
  end
  // ==========================================
  // Drivers
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDat <= dat;
    do begin
      @(negedge core_clk);
      seen = wbAck || wbErr;
      @(posedge core_clk);
      n++;
    end while (!seen && n < 50);
    if (n >= 50) begin
      num_errors++;
      close_out;
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [1:0] k = 0);
    notes.push_back({k, exp});
    bus(1'b0, adr, 32'h0);
  endtask
  task automatic hit(input logic [15:0] adr, input logic dir);
    busValid <= 1'b1;
    busAddr <= adr;
    busRead <= dir;
    @(posedge core_clk);
    busValid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 20 && notes.size() != 0; n++) @(posedge core_clk);
    if (notes.size() != 0) begin
      num_errors++;
      close_out;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(98));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(OFS_CONTROL, {24'h0, CONTROL_RST});
    rd(OFS_TRIGGER, {24'h0, TRIGGER_RST});
    rd(8'h0C, 32'h0, 2'd1);
    chipSecure <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b1, OFS_CONTROL, 32'h80);
    rd(OFS_CONTROL, 32'h0);
    chipSecure <= 1'b0;
    repeat (3) @(posedge core_clk);
    r = $urandom & 32'hBF;
    bus(1'b1, OFS_CONTROL, r);
    rd(OFS_CONTROL, r);
    bus(1'b1, OFS_TRIGGER, 32'hFF);
    rd(OFS_TRIGGER, 32'hCF);
    cmpA <= 16'($urandom);
    cmpB <= 16'hFFFF;
    for (int t = 0; t < 2; t++) begin
      bus(1'b1, OFS_TRIGGER, 32'h0);
      bus(1'b1, OFS_CONTROL, 32'hD0 | 32'(t << 5));
      bus(1'b1, OFS_TRIGGER, 32'h0F);
      rd(OFS_TRIGGER, 32'h0);
      notes.push_back({2'd2, 32'(t)});
      hit(cmpA, 1'b0);
      drain;
      rd(OFS_CONTROL, 32'h90 | 32'(t << 5));
    end
    for (int m = 9; m < 16; m++) begin
      bus(1'b1, OFS_CONTROL, 32'h0);
      bus(1'b1, OFS_TRIGGER, 32'(m));
      bus(1'b1, OFS_CONTROL, 32'hD0);
      hit(cmpA, 1'b0);
      rd(OFS_CONTROL, 32'hD0);
    end
    bus(1'b1, OFS_CONTROL, 32'h90);
    bus(1'b1, OFS_TRIGGER, 32'h0);
    hit(cmpA, 1'b0);
    bus(1'b1, OFS_CONTROL, 32'hDC);
    hit(cmpA, 1'b0);
    notes.push_back({2'd2, 32'h0});
    hit(cmpA, 1'b1);
    drain;
    bus(1'b1, OFS_TRIGGER, 32'h80);
    bus(1'b1, OFS_CONTROL, 32'hD0);
    hit(cmpA, 1'b0);
    opExecA <= 1'b1;
    notes.push_back({2'd2, 32'h0});
    hit(cmpA, 1'b0);
    drain;
    opExecA <= 1'b0;
    bus(1'b1, OFS_TRIGGER, 32'h05);
    bus(1'b1, OFS_CONTROL, 32'hD0);
    hit(cmpA, 1'b0);
    dataBMatch <= 1'b1;
    notes.push_back({2'd2, 32'h0});
    hit(cmpA, 1'b0);
    drain;
    dataBMatch <= 1'b0;
    bus(1'b1, OFS_TRIGGER, 32'h40);
    bus(1'b1, OFS_CONTROL, 32'hD0);
    notes.push_back({2'd2, 32'h0});
    hit(cmpA, 1'b0);
    repeat (9) hit(cmpA + 16'h1, 1'b0);
    drain;
    close_out;
  end
endmodule
